// ===== hw/chan_seq_regs.svh
// constants of the power channel sequencer and servo
// Overview of operation
// R1 - ignore turn-on sources until input above on threshold
// R2 - input below off threshold turns all channels off
// R3 - per-channel turn-on source is selectable
// R4 - wait on delay before asserting converter enable
// R5 - after rise time, soft-connect and servo output
// R6 - at max rise time check undervoltage, maybe fault
// R7 - overvoltage checked always, except margin-ignore or reset
// R8 - on state chooses margin high, low or nominal
// R9 - config bit 7 gives continuous closed-loop trim
// R10 - non-continuous trim stops once target reached
// R11 - fast servo steps one lsb per period
// R12 - bit 6 re-servos on warning limit excursion
// R13 - soft-connect matches dac to feedback first
// R14 - disconnected mode keeps trim output high impedance
// R15 - manual soft-connect matches, then follows register
// R16 - manual hard connect uses register immediately
// R17 - margin targets stored, triggered by operation only
// R18 - margin requests ignored while dac disconnected
// R19 - off sequence drops enable after off delay
// R20 - off threshold is factor times vout command
// R21 - output above off threshold holds channel off
// R22 - shared millisecond time base for all timers
`ifndef CHAN_SEQ_REGS_SVH
`define CHAN_SEQ_REGS_SVH
`define CLK_PERIOD_PS 5000
`define TICK_PERIOD_PS 1000000000
`define TICK_CYCLES (`TICK_PERIOD_PS / `CLK_PERIOD_PS)
`define FAST_STEP_NS 60
`define FAST_STEP_CYCLES ((`FAST_STEP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CFG_CONT_BIT 7
`define CFG_WARN_BIT 6
`define CFG_FAST_OFF_BIT 5
`define CFG_DACMODE_LSB 0
`define CFG_TRACK_BIT 2
`define NEAR_WINDOW 16'h0040
`define DAC_RESET 10'h200
`endif

// ===== hw/chan_seq_pkg.sv
// types of the power channel sequencer and servo
package chan_seq_pkg;
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_TON = 6'h02,
    ST_RISE = 6'h04,
    ST_MAXW = 6'h08,
    ST_ON = 6'h10,
    ST_TOFF = 6'h20
  } chan_state_t;
  typedef enum logic [1:0] {
    SRC_VIN = 2'h0,
    SRC_OP = 2'h1,
    SRC_PIN = 2'h2,
    SRC_BOTH = 2'h3
  } on_src_t;
  typedef enum logic [1:0] {
    DAC_SOFT = 2'h0,
    DAC_OFF = 2'h1,
    DAC_MAN_SOFT = 2'h2,
    DAC_MAN_HARD = 2'h3
  } dac_mode_t;
  typedef enum logic [1:0] {
    TGT_NOM = 2'h0,
    TGT_LOW = 2'h1,
    TGT_HIGH = 2'h2
  } target_t;
endpackage : chan_seq_pkg

// ===== hw/ms_tick.sv
// millisecond time base shared by all channel timers
`timescale 1ns/10ps
`include "chan_seq_regs.svh"
module ms_tick
  import chan_seq_pkg::*;
#(
  parameter int CYCLES = `TICK_CYCLES
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire logic sync, // restarts the period
  output logic tick // one-cycle pulse per period
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_st_t;
  tick_st_t s_reg, s_next;
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (sync || s_reg.cnt == 32'(CYCLES - 1))
    begin
      s_next.cnt = 32'h0;
      s_next.tick = !sync;
    end
    else
      s_next.cnt = s_reg.cnt + 32'h1;
  end
  always_ff @(posedge clk or posedge rst)
    if (rst)
      s_reg <= '0;
    else if (ce)
      s_reg <= s_next;
  assign tick = s_reg.tick;
endmodule : ms_tick

// ===== hw/power_channel_sequencer_servo.sv
// per-channel sequencing, trim servo and margining for four converters
`timescale 1ns/10ps
`include "chan_seq_regs.svh"
module power_channel_sequencer_servo
  import chan_seq_pkg::*;
#(
  parameter int NCH = 4,
  parameter int TICK_CYC = `TICK_CYCLES,
  parameter int STEP_CYC = `FAST_STEP_CYCLES
) (
  input wire logic clk, // 200 mhz clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic vin_above_on, // input voltage above on threshold
  input wire logic vin_below_off, // input voltage below off threshold
  input wire logic control_on, // control pin in its on level
  input wire logic op_on, // operation command on bit
  input wire logic op_wr, // operation write strobe
  input wire logic [1:0] op_margin, // operation margin target code
  input wire logic [NCH*8-1:0] channel_servo_config, // per-channel config
  input wire logic [NCH*2-1:0] on_source, // per-channel turn-on source
  input wire logic [NCH*16-1:0] ton_delay, // on delay, ms
  input wire logic [NCH*16-1:0] ton_rise, // rise time, ms
  input wire logic [NCH*16-1:0] ton_max, // max rise fault time, ms
  input wire logic [NCH*16-1:0] toff_delay, // off delay, ms
  input wire logic [NCH*16-1:0] vout_command, // nominal target
  input wire logic [NCH*16-1:0] margin_high, // margin high target
  input wire logic [NCH*16-1:0] margin_low, // margin low target
  input wire logic [NCH*16-1:0] ov_fault_limit, // overvoltage limit
  input wire logic [NCH*16-1:0] uv_fault_limit, // undervoltage limit
  input wire logic [NCH*16-1:0] ov_warn_limit, // overvoltage warning
  input wire logic [NCH*16-1:0] uv_warn_limit, // undervoltage warning
  input wire logic [NCH*8-1:0] off_threshold_factor, // factor, 1/256 units
  input wire logic [NCH-1:0] ov_ignore_margin, // ignore ov when margined
  input wire logic [NCH-1:0] uv_fault_off, // ton max fault disables
  input wire logic [NCH*16-1:0] vout_read, // latest adc output reading
  input wire logic [NCH-1:0] vout_valid, // reading strobe
  input wire logic [NCH*10-1:0] feedback_code, // feedback node as dac code
  input wire logic [NCH*10-1:0] manual_dac, // manual dac register
  input wire logic [1:0] shared_fault_line_in, // shared fault lines level
  output logic [1:0] shared_fault_line_out, // drive level, always low
  output logic [1:0] shared_fault_line_oe_n, // low while pulling line low
  output logic [NCH-1:0] vout_en, // converter enables
  output logic [NCH*10-1:0] trim_dac_out, // trim dac codes
  output logic [NCH-1:0] trim_dac_oe_n, // low while dac connected
  output logic [NCH-1:0] ov_fault, // overvoltage fault, level
  output logic [NCH-1:0] ton_max_fault, // undervoltage at ton max, sticky
  output logic [NCH-1:0] off_thresh_status, // held off above threshold
  output logic alert_n // alert line, low active
);
  logic tick;
  logic seq_start;
  logic vin_seen_reg;
  // R22 common time base
  ms_tick #(.CYCLES(TICK_CYC)) u_tick (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .sync(seq_start),
    .tick(tick)
  );
  typedef struct packed {
    chan_state_t st;
    logic [15:0] tmr;
    logic en;
    logic [9:0] dac;
    logic conn;
    logic servo;
    logic fast;
    logic [15:0] step;
    target_t tgt;
    logic ovf;
    logic uvf;
    logic held;
    logic [9:0] man;
  } ch_t;
  typedef struct packed {
    ch_t [NCH-1:0] ch;
    logic on_req;
    logic [1:0] flt_oe_n;
    logic alert_n;
  } st_t;
  st_t s_reg, s_next;
  // R1 gate turn-on until input voltage qualified
  always_ff @(posedge clk or posedge rst)
    if (rst)
      vin_seen_reg <= 1'b0;
    else if (ce)
      vin_seen_reg <= vin_below_off ? 1'b0 : (vin_seen_reg | vin_above_on);
  logic [NCH-1:0] want_on;
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      // R3 turn-on source selection
      unique case (on_src_t'(on_source[i*2 +: 2]))
        SRC_VIN: want_on[i] = vin_seen_reg;
        SRC_OP: want_on[i] = vin_seen_reg & op_on;
        SRC_PIN: want_on[i] = vin_seen_reg & control_on;
        SRC_BOTH: want_on[i] = vin_seen_reg & op_on & control_on;
      endcase
    end
  end
  assign seq_start = (|want_on) != s_reg.on_req;
  always_comb
  begin
    logic [15:0] rd;
    logic [15:0] tg;
    logic [23:0] thr;
    logic [7:0] cf;
    dac_mode_t dm;
    rd = '0;
    tg = '0;
    thr = '0;
    cf = '0;
    dm = DAC_SOFT;
    s_next = s_reg;
    s_next.on_req = |want_on;
    s_next.flt_oe_n = 2'h3;
    for (int i = 0; i < NCH; i++)
    begin
      rd = vout_read[i*16 +: 16];
      cf = channel_servo_config[i*8 +: 8];
      dm = dac_mode_t'(cf[`CFG_DACMODE_LSB +: 2]);
      if (tick && s_reg.ch[i].tmr != 16'h0)
        s_next.ch[i].tmr = s_reg.ch[i].tmr - 16'h1;
      // R20 off threshold product
      thr = 24'(off_threshold_factor[i*8 +: 8] * vout_command[i*16 +: 16]);
      // R7 continuous overvoltage check
      s_next.ch[i].ovf = rd > ov_fault_limit[i*16 +: 16] &&
        !(ov_ignore_margin[i] && s_reg.ch[i].tgt != TGT_NOM);
      unique case (s_reg.ch[i].st)
        ST_OFF:
        begin
          s_next.ch[i].en = 1'b0;
          s_next.ch[i].conn = 1'b0;
          s_next.ch[i].servo = 1'b0;
          s_next.ch[i].tgt = TGT_NOM;
          if (want_on[i] && !s_reg.ch[i].uvf)
          begin
            // R21 hold off while output above threshold
            if (rd > thr[23:8])
              s_next.ch[i].held = 1'b1;
            else
            begin
              s_next.ch[i].held = 1'b0;
              s_next.ch[i].st = ST_TON;
              s_next.ch[i].tmr = ton_delay[i*16 +: 16];
            end
          end
          else
            s_next.ch[i].held = 1'b0;
        end
        ST_TON:
          // R4 on delay before enable
          if (s_reg.ch[i].tmr == 16'h0)
          begin
            s_next.ch[i].en = 1'b1;
            s_next.ch[i].st = ST_RISE;
            s_next.ch[i].tmr = ton_rise[i*16 +: 16];
          end
        ST_RISE:
          // R5 connect only once rise time expired
          if (s_reg.ch[i].tmr == 16'h0)
          begin
            s_next.ch[i].st = ST_MAXW;
            s_next.ch[i].tmr = (ton_max[i*16 +: 16] > ton_rise[i*16 +: 16]) ?
              16'(ton_max[i*16 +: 16] - ton_rise[i*16 +: 16]) : 16'h0;
            // R14 disconnected mode leaves dac floating
            if (dm != DAC_OFF)
            begin
              s_next.ch[i].conn = 1'b1;
              // R13 R15 soft-connect matches feedback first
              // R16 hard connect uses manual code
              s_next.ch[i].dac = (dm == DAC_MAN_HARD) ? manual_dac[i*10 +: 10]
                : feedback_code[i*10 +: 10];
              s_next.ch[i].servo = (dm == DAC_SOFT);
              // R11 fast servo on new soft-connect
              s_next.ch[i].fast = (dm == DAC_SOFT) && !cf[`CFG_FAST_OFF_BIT];
            end
          end
        ST_MAXW:
          // R6 undervoltage check at max rise time
          if (s_reg.ch[i].tmr == 16'h0)
          begin
            s_next.ch[i].st = ST_ON;
            if (rd < uv_fault_limit[i*16 +: 16] && uv_fault_off[i])
            begin
              s_next.ch[i].uvf = 1'b1;
              s_next.ch[i].st = ST_OFF;
              s_next.ch[i].en = 1'b0;
            end
          end
        ST_ON:
        begin
          // R8 R17 R18 margin from operation writes
          if (op_wr && s_reg.ch[i].conn && dm == DAC_SOFT &&
              target_t'(op_margin) != s_reg.ch[i].tgt)
          begin
            s_next.ch[i].tgt = target_t'(op_margin);
            s_next.ch[i].servo = 1'b1;
            s_next.ch[i].fast = !cf[`CFG_FAST_OFF_BIT];
          end
          // R12 re-servo on warning excursion
          if (!cf[`CFG_CONT_BIT] && cf[`CFG_WARN_BIT] && vout_valid[i] &&
              (rd > ov_warn_limit[i*16 +: 16] || rd < uv_warn_limit[i*16 +: 16]))
            s_next.ch[i].servo = s_reg.ch[i].conn && dm == DAC_SOFT;
        end
        ST_TOFF:
          // R19 enable drops after off delay
          if (s_reg.ch[i].tmr == 16'h0)
            s_next.ch[i].st = ST_OFF;
        default:
          s_next.ch[i].st = ST_OFF;
      endcase
      // R15 R16 manual code follows writes
      if (s_reg.ch[i].st inside {ST_MAXW, ST_ON} && (dm == DAC_MAN_HARD ||
          (dm == DAC_MAN_SOFT && manual_dac[i*10 +: 10] != s_reg.ch[i].man)))
        s_next.ch[i].dac = manual_dac[i*10 +: 10];
      s_next.ch[i].man = manual_dac[i*10 +: 10];
      unique case (s_reg.ch[i].tgt)
        TGT_HIGH: tg = margin_high[i*16 +: 16];
        TGT_LOW: tg = margin_low[i*16 +: 16];
        default: tg = vout_command[i*16 +: 16];
      endcase
      if (s_reg.ch[i].step != 16'h0)
        s_next.ch[i].step = s_reg.ch[i].step - 16'h1;
      if (s_reg.ch[i].servo && s_reg.ch[i].conn && dm == DAC_SOFT)
      begin
        if (s_reg.ch[i].fast)
        begin
          // R11 one lsb per step period until near
          if ((rd > tg ? rd - tg : tg - rd) < `NEAR_WINDOW)
            s_next.ch[i].fast = 1'b0;
          else if (s_reg.ch[i].step == 16'h0)
          begin
            s_next.ch[i].step = 16'(STEP_CYC - 1);
            s_next.ch[i].dac = (rd > tg) ? s_reg.ch[i].dac - 10'h1
              : s_reg.ch[i].dac + 10'h1;
          end
        end
        else if (vout_valid[i])
        begin
          // R9 R10 slow servo per reading
          if (rd > tg)
            s_next.ch[i].dac = s_reg.ch[i].dac - 10'h1;
          else if (rd < tg)
            s_next.ch[i].dac = s_reg.ch[i].dac + 10'h1;
          else if (!cf[`CFG_CONT_BIT])
            s_next.ch[i].servo = 1'b0;
        end
      end
      // R2 R19 off request starts timed or immediate off
      if (s_reg.ch[i].st != ST_OFF && s_reg.ch[i].st != ST_TOFF && !want_on[i])
      begin
        s_next.ch[i].st = ST_TOFF;
        s_next.ch[i].tmr = toff_delay[i*16 +: 16];
        if (vin_below_off && !cf[`CFG_TRACK_BIT])
          s_next.ch[i].st = ST_OFF;
      end
      if (s_next.ch[i].st == ST_OFF)
      begin
        s_next.ch[i].en = 1'b0;
        s_next.ch[i].conn = 1'b0;
      end
      if (!want_on[i] && s_reg.ch[i].uvf)
        s_next.ch[i].uvf = 1'b0;
      if (s_reg.ch[i].uvf)
        s_next.flt_oe_n = 2'h0;
    end
    s_next.alert_n = 1'b1;
    for (int i = 0; i < NCH; i++)
      if (s_next.ch[i].held || s_next.ch[i].uvf || s_next.ch[i].ovf)
        s_next.alert_n = 1'b0;
  end
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      s_reg <= '0;
      s_reg.flt_oe_n <= 2'h3;
      s_reg.alert_n <= 1'b1;
      for (int i = 0; i < NCH; i++)
      begin
        s_reg.ch[i].st <= ST_OFF;
        s_reg.ch[i].dac <= `DAC_RESET;
      end
    end
    else if (ce)
      s_reg <= s_next;
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      vout_en[i] = s_reg.ch[i].en;
      trim_dac_out[i*10 +: 10] = s_reg.ch[i].dac;
      trim_dac_oe_n[i] = !s_reg.ch[i].conn;
      ov_fault[i] = s_reg.ch[i].ovf;
      ton_max_fault[i] = s_reg.ch[i].uvf;
      off_thresh_status[i] = s_reg.ch[i].held;
    end
  end
  assign shared_fault_line_out = 2'h0;
  assign shared_fault_line_oe_n = s_reg.flt_oe_n;
  assign alert_n = s_reg.alert_n;
  // R4 enable never before on delay stage ends
  enable_order_a: assert property (@(posedge clk) disable iff (rst)
    $rose(vout_en[0]) |-> $past(s_reg.ch[0].st) == ST_TON) // R4
    else $error("enable without on delay");
  // R5 connect follows rise stage
  connect_order_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s_reg.ch[0].conn) |-> $past(s_reg.ch[0].st) == ST_RISE && vout_en[0]) // R5
    else $error("dac connected before rise");
  // R14 disconnected mode
  dac_float_a: assert property (@(posedge clk) disable iff (rst)
    dac_mode_t'(channel_servo_config[25:24]) == DAC_OFF && $stable(channel_servo_config)
    |=> !$rose(s_reg.ch[3].conn)) // R14
    else $error("dac connected in disconnected mode");
  // R21 held channel stays off
  held_off_a: assert property (@(posedge clk) disable iff (rst)
    off_thresh_status[0] |-> !vout_en[0] && !alert_n) // R21
    else $error("held channel enabled");
  // R1 no turn-on without vin
  vin_gate_a: assert property (@(posedge clk) disable iff (rst)
    !vin_seen_reg && s_reg.ch[0].st == ST_OFF |=> s_reg.ch[0].st == ST_OFF) // R1
    else $error("turn-on without input voltage");
  // R18 margin ignored while disconnected
  margin_drop_a: assert property (@(posedge clk) disable iff (rst || !ce)
    !s_reg.ch[3].conn |=> s_reg.ch[3].tgt == TGT_NOM) // R18
    else $error("margin taken while disconnected");
  // R6 fault line pulled after undervoltage
  fault_prop_a: assert property (@(posedge clk) disable iff (rst || !ce)
    |ton_max_fault |=> shared_fault_line_oe_n == 2'h0) // R6
    else $error("fault not propagated");
  // R19 off stage drops to off at zero
  off_delay_a: assert property (@(posedge clk) disable iff (rst || !ce)
    s_reg.ch[1].st == ST_TOFF && s_reg.ch[1].tmr == 16'h0 && !want_on[1]
    |=> !vout_en[1]) // R19
    else $error("enable held past off delay");
endmodule : power_channel_sequencer_servo

// ===== verif/converter_model.sv
// behavioural model of four dc/dc converters with trim input and adc readback
`timescale 1ns/10ps
module converter_model #(
  parameter int NCH = 4
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic [NCH-1:0] vout_en, // converter enables
  input wire logic [NCH*10-1:0] trim_dac_out, // trim codes
  input wire logic [NCH-1:0] trim_dac_oe_n, // low while connected
  input wire logic [NCH-1:0] dead, // output never rises
  input wire logic [15:0] disturb, // load step seen by readings
  output logic [NCH*16-1:0] vout_read, // adc readings
  output logic [NCH-1:0] vout_valid, // reading strobe
  output logic [NCH*10-1:0] feedback_code // feedback node as code
);
  localparam logic [15:0] NOM = 16'h1000;
  localparam logic [9:0] FB = 10'h1f0;
  logic [15:0] vo [NCH];
  logic [2:0] scan;
  // feedback node sits at its own level until the dac pulls it
  always_comb
    for (int i = 0; i < NCH; i++)
      feedback_code[i*10 +: 10] = trim_dac_oe_n[i] ? FB : trim_dac_out[i*10 +: 10];
  always @(posedge clk or posedge rst)
  begin : step
    logic [15:0] t;
    if (rst)
    begin
      scan <= 3'h0;
      vout_valid <= '0;
      vout_read <= '0;
      for (int i = 0; i < NCH; i++) vo[i] <= 16'h0;
    end
    else
    begin
      scan <= scan + 3'h1;
      vout_valid <= {NCH{scan == 3'h0}};
      for (int i = 0; i < NCH; i++)
      begin
        t = trim_dac_oe_n[i] ? NOM : NOM + {6'h0, trim_dac_out[i*10 +: 10]} - {6'h0, FB};
        if (dead[i]) t = 16'h0;
        // slow discharge keeps the output above the off threshold for a while
        if (!vout_en[i]) vo[i] <= (vo[i] > 16'h8) ? vo[i] - 16'h8 : 16'h0;
        else if (vo[i] + 16'h40 < t) vo[i] <= vo[i] + 16'h40;
        else if (vo[i] > t + 16'h40) vo[i] <= vo[i] - 16'h40;
        else vo[i] <= t;
        vout_read[i*16 +: 16] <= vo[i] + (vout_en[i] ? disturb : 16'h0);
      end
    end
  end
endmodule : converter_model

// ===== verif/power_channel_sequencer_servo_test.sv
// self-checking bench of the channel sequencer and trim servo
`timescale 1ns/10ps
module power_channel_sequencer_servo_test;
  import chan_seq_pkg::*;
  typedef struct packed {logic vin; logic pin; logic op; logic [3:0] en;} row_t;
  localparam row_t ROWS [6] = '{'{1'b0, 1'b1, 1'b1, 4'h0}, '{1'b1, 1'b0, 1'b0, 4'h1},
    '{1'b1, 1'b1, 1'b0, 4'h5}, '{1'b1, 1'b0, 1'b1, 4'h3}, '{1'b1, 1'b1, 1'b1, 4'hf},
    '{1'b1, 1'b0, 1'b0, 4'h1}};
  logic clk, rst, ce, vin_above_on, vin_below_off, control_on, op_on, op_wr;
  logic [1:0] op_margin, fault_wire, shared_fault_line_out, shared_fault_line_oe_n;
  logic [31:0] channel_servo_config, off_threshold_factor;
  logic [7:0] on_source;
  logic [63:0] ton_delay, ton_rise, ton_max, toff_delay, vout_command, margin_high;
  logic [63:0] margin_low, ov_fault_limit, uv_fault_limit, ov_warn_limit, uv_warn_limit;
  logic [63:0] vout_read;
  logic [39:0] feedback_code, manual_dac, trim_dac_out;
  logic [3:0] ov_ignore_margin, uv_fault_off, vout_valid, vout_en, trim_dac_oe_n, dead;
  logic [3:0] ov_fault, ton_max_fault, off_thresh_status, en_q, oe_q;
  logic alert_n;
  logic [15:0] disturb;
  logic [15:0] tg [3] = '{16'h1080, 16'h0fa0, 16'h1010};
  logic [9:0] s0, s1;
  int miscompares = 0;
  int num_checks = 0;
  int cycn = 0;
  int rise_at [4];
  assign fault_wire = shared_fault_line_oe_n | shared_fault_line_out;
  power_channel_sequencer_servo #(.NCH(4), .TICK_CYC(10)) u_power_channel_sequencer_servo (
    .clk(clk), .rst(rst), .ce(ce), .vin_above_on(vin_above_on), .vin_below_off(vin_below_off),
    .control_on(control_on), .op_on(op_on), .op_wr(op_wr), .op_margin(op_margin),
    .channel_servo_config(channel_servo_config), .on_source(on_source), .ton_delay(ton_delay),
    .ton_rise(ton_rise), .ton_max(ton_max), .toff_delay(toff_delay), .vout_command(vout_command),
    .margin_high(margin_high), .margin_low(margin_low), .ov_fault_limit(ov_fault_limit),
    .uv_fault_limit(uv_fault_limit), .ov_warn_limit(ov_warn_limit),
    .uv_warn_limit(uv_warn_limit), .off_threshold_factor(off_threshold_factor),
    .ov_ignore_margin(ov_ignore_margin), .uv_fault_off(uv_fault_off), .vout_read(vout_read),
    .vout_valid(vout_valid), .feedback_code(feedback_code), .manual_dac(manual_dac),
    .shared_fault_line_in(fault_wire), .shared_fault_line_out(shared_fault_line_out),
    .shared_fault_line_oe_n(shared_fault_line_oe_n), .vout_en(vout_en),
    .trim_dac_out(trim_dac_out), .trim_dac_oe_n(trim_dac_oe_n), .ov_fault(ov_fault),
    .ton_max_fault(ton_max_fault), .off_thresh_status(off_thresh_status), .alert_n(alert_n));
  converter_model #(.NCH(4)) u_converter_model (.clk(clk), .rst(rst), .vout_en(vout_en),
    .trim_dac_out(trim_dac_out), .trim_dac_oe_n(trim_dac_oe_n), .dead(dead),
    .disturb(disturb), .vout_read(vout_read), .vout_valid(vout_valid),
    .feedback_code(feedback_code));
  always #2.5 clk = ~clk;
  // ***************
  // helpers
  // ***************
  function automatic logic [9:0] dac(input int i);
    return trim_dac_out[i*10 +: 10];
  endfunction : dac
  function automatic logic [15:0] vo(input int i);
    return vout_read[i*16 +: 16];
  endfunction : vo
  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_eq
  task automatic check_near(input logic [15:0] got, input logic [15:0] exp, input int tol);
    num_checks++;
    if ((got + 16'(tol) >= exp && got <= exp + 16'(tol)) !== 1'b1)
    begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_near
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic set_vin(input logic v);
    vin_above_on = v;
    vin_below_off = !v;
  endtask : set_vin
  task automatic op_write(input logic on, input logic [1:0] m);
    op_on = on;
    op_margin = m;
    op_wr = 1'b1;
    cyc(1);
    op_wr = 1'b0;
  endtask : op_write
  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // connect monitor: timing after enable and code at the moment of connection
  always @(posedge clk)
  begin
    cycn++;
    for (int i = 0; i < 4; i++)
    begin
      if (vout_en[i] && !en_q[i]) rise_at[i] = cycn;
      if (!trim_dac_oe_n[i] && oe_q[i] && i < 2)
      begin
        check_eq(16'(cycn - rise_at[i] > 10 && cycn - rise_at[i] < 25), 16'h1);
        check_near(16'(dac(i)), 16'h1f0, 1);
      end
      if (!trim_dac_oe_n[i] && oe_q[i] && i == 2 && &channel_servo_config[17:16])
        check_eq(16'(dac(2)), 16'(manual_dac[29:20]));
      if (!trim_dac_oe_n[i] && oe_q[i] && i == 2 && channel_servo_config[17:16] == 2'h2)
        check_eq(16'(dac(2)), 16'h1f0);
    end
    en_q = vout_en;
    oe_q = trim_dac_oe_n;
  end
  initial
  begin
    #300000;
    miscompares++;
    tally_and_finish;
  end
  // ***************
  // main sequence
  // ***************
  initial
  begin
    clk = 0; rst = 1; ce = 1; en_q = '0; oe_q = '1; dead = '0; disturb = '0;
    set_vin(0); control_on = 0; op_on = 0; op_wr = 0; op_margin = 2'h0;
    channel_servo_config = {8'h05, 8'h07, 8'h44, 8'h80};
    on_source = {2'h3, 2'h2, 2'h1, 2'h0};
    ton_delay = {16'h4, 16'h3, 16'h2, 16'h1};
    ton_rise = {4{16'h2}}; ton_max = {4{16'h8}}; toff_delay = {4{16'h2}};
    vout_command = {4{16'h1010}}; margin_high = {4{16'h1080}}; margin_low = {4{16'h0fa0}};
    ov_fault_limit = {4{16'h1200}}; uv_fault_limit = {4{16'h0800}};
    ov_warn_limit = {4{16'h1050}}; uv_warn_limit = {4{16'h0fd0}};
    off_threshold_factor = {4{8'h80}}; ov_ignore_margin = '0; uv_fault_off = 4'hf;
    manual_dac = {10'h0, 10'h155, 20'h0};
    cyc(6);
    rst = 0;
    foreach (ROWS[r])
    begin
      set_vin(ROWS[r].vin);
      control_on = ROWS[r].pin;
      op_write(ROWS[r].op, 2'h0);
      cyc(700);
      check_eq(16'(vout_en), 16'(ROWS[r].en));
    end
    set_vin(0);
    rst = 1;
    cyc(2);
    check_eq(16'(vout_en), 16'h0);
    check_eq(16'(trim_dac_oe_n), 16'hf);
    check_eq(16'(alert_n), 16'h1);
    for (int i = 0; i < 4; i++) check_eq(16'(dac(i)), 16'h200);
    cyc(4);
    rst = 0;
    op_write(1'b1, 2'h0);
    control_on = 1;
    cyc(2);
    set_vin(1);
    for (int k = 0; k < 5; k++)
    begin
      cyc(k == 0 ? 5 : 10);
      check_eq(16'(vout_en), 16'(4'((5'h1 << k) - 5'h1)));
    end
    cyc(300);
    manual_dac[20 +: 10] = 10'h2aa;
    cyc(5);
    check_eq(16'(dac(2)), 16'h2aa);
    cyc(2500);
    s0 = dac(0);
    s1 = dac(1);
    disturb = 16'h8;
    cyc(500);
    check_eq(16'(dac(0) !== s0), 16'h1);
    check_eq(16'(dac(1)), 16'(s1));
    disturb = 16'h60;
    cyc(500);
    check_eq(16'(dac(1) !== s1), 16'h1);
    disturb = 16'h0;
    for (int m = 0; m < 3; m++)
    begin
      op_write(1'b1, 2'(2 - m));
      cyc(3000);
      check_near(vo(0), tg[m], 2);
      check_near(vo(1), tg[m], 2);
      check_eq(16'(trim_dac_oe_n[3]), 16'h1);
    end
    ov_fault_limit[16 +: 16] = 16'h0800;
    cyc(3);
    check_eq(16'(ov_fault), 16'h2);
    ov_fault_limit[16 +: 16] = 16'h1200;
    cyc(3);
    check_eq(16'(ov_fault), 16'h0);
    set_vin(0);
    cyc(3);
    check_eq(16'(vout_en), 16'he);
    cyc(30);
    check_eq(16'(vout_en), 16'h0);
    channel_servo_config[16 +: 8] = 8'h06;
    set_vin(1);
    cyc(10);
    check_eq(16'(off_thresh_status), 16'hf);
    check_eq(16'({alert_n, vout_en}), 16'h0);
    cyc(700);
    check_eq(16'({alert_n, off_thresh_status, vout_en}), 16'h10f);
    check_eq(16'(dac(2)), 16'h1f0);
    manual_dac[20 +: 10] = 10'h0aa;
    cyc(3);
    check_eq(16'(dac(2)), 16'h0aa);
    op_write(1'b0, 2'h0);
    cyc(700);
    check_eq(16'(vout_en), 16'h5);
    dead = 4'h8;
    op_write(1'b1, 2'h0);
    cyc(300);
    check_eq(16'(ton_max_fault), 16'h8);
    check_eq(16'({&fault_wire, vout_en}), 16'h7);
    tally_and_finish;
  end
endmodule : power_channel_sequencer_servo_test
